// *** core/thc_control_word.sv ***
`timescale 1ns/10ps
module thc_control_word
	import thc_pkg::*;
#(
	parameter int TICK_CYCLES = THC_TICK_CYC,
	parameter int IDLE_TICKS = THC_IDLE_MS
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// control word as fetched over the host link
	input wire logic [THC_WORD_W-1:0] ctrl_word_in,
	input wire logic ctrl_word_valid_in,
	// operator and host screen events
	input wire logic key_press_in,
	input wire logic screen_switch_req_in,
	input wire logic attr_blank_in,
	// memory switch: automatic backlight off
	input wire logic idle_off_enable_in,
	// terminal outputs
	output logic backlight_on_out,
	output logic hist_print_req_out,
	output logic report_print_req_out,
	output logic [THC_WORD_W-1:0] ctrl_word_out
);
	typedef struct packed {
		logic [THC_WORD_W-1:0] word;
		logic seen;
		logic light;
		logic hist;
		logic rep;
		logic key_s1;
		logic key_s2;
		logic key_d;
	} thc_state_s;

	thc_state_s st_r;
	thc_state_s st_nxt;
	logic idle_expire;
	logic key_edge;
	logic upd;
	logic scr_rise;
	logic scr_fall;
	logic hist_rise;
	logic rep_rise;
	logic activity;

	function automatic logic bit_rise(input logic [THC_WORD_W-1:0] old_w,
			input logic [THC_WORD_W-1:0] new_w, input int pos);
		bit_rise = !old_w[pos] && new_w[pos];
	endfunction

	assign key_edge = st_r.key_s2 && !st_r.key_d;
	// a word is only acted on once a start-up baseline exists
	assign upd = ctrl_word_valid_in && st_r.seen;
	assign scr_rise = upd && bit_rise(st_r.word, ctrl_word_in, THC_BIT_SCREEN);
	assign scr_fall = upd && bit_rise(ctrl_word_in, st_r.word, THC_BIT_SCREEN);
	assign hist_rise = upd && bit_rise(st_r.word, ctrl_word_in, THC_BIT_HIST);
	assign rep_rise = upd && bit_rise(st_r.word, ctrl_word_in, THC_BIT_REPORT);
	assign activity = key_edge || screen_switch_req_in || scr_rise;

	thc_idle_timer #(
		.TICK_CYCLES(TICK_CYCLES),
		.IDLE_TICKS(IDLE_TICKS)
	) u_idle (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.enable_in(idle_off_enable_in && st_r.light),
		.restart_in(activity),
		.expire_out(idle_expire)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.key_s1 = key_press_in;
		st_nxt.key_s2 = st_r.key_s1;
		st_nxt.key_d = st_r.key_s2;
		st_nxt.hist = 1'b0;
		st_nxt.rep = 1'b0;
		if (ctrl_word_valid_in) begin
			// local copy only; nothing here ever writes back to the host
			st_nxt.word = ctrl_word_in;
			st_nxt.seen = 1'b1;
		end
		// only bits 15, 5 and 4 reach any decision below
		st_nxt.hist = hist_rise;
		st_nxt.rep = rep_rise;
		// lowest priority: automatic idle off
		if (idle_expire && idle_off_enable_in) begin
			st_nxt.light = 1'b0;
		end
		if (key_edge || scr_rise) begin
			st_nxt.light = 1'b1;
		end
		if (screen_switch_req_in) begin
			st_nxt.light = 1'b1;
		end
		// an explicit host clear wins over every relight source
		if (scr_fall) begin
			st_nxt.light = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st_r <= '{word: THC_WORD_RST, light: THC_LIGHT_RST, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// blanking by screen attribute does not touch the word copy
	assign backlight_on_out = st_r.light;
	assign hist_print_req_out = st_r.hist;
	assign report_print_req_out = st_r.rep;
	assign ctrl_word_out = st_r.word;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);

	a_light_off_cmd: assert property (
		scr_fall |=> !backlight_on_out
	) else $error("backlight not off after screen bit cleared");

	a_relight_key: assert property (
		(key_edge || scr_rise) && !scr_fall |=> backlight_on_out
	) else $error("backlight not relit by key or screen bit");

	a_key_sync_lat: assert property (
		!backlight_on_out && !key_press_in ##1 key_press_in [*3]
			##0 !screen_switch_req_in && !ctrl_word_valid_in
			|=> backlight_on_out
	) else $error("key press did not relight within sync latency");

	a_hist_once: assert property (
		hist_print_req_out |-> $past(hist_rise) ##1 !hist_print_req_out
	) else $error("history print request not a single caused pulse");

	a_hist_cause: assert property (
		hist_rise |=> hist_print_req_out
	) else $error("history print not requested on bit 5 rise");

	a_report_once: assert property (
		rep_rise |=> report_print_req_out ##1 !report_print_req_out
	) else $error("report print not a single pulse on bit 4 rise");

	a_report_cause: assert property (
		report_print_req_out |-> $past(rep_rise)
	) else $error("report print requested without bit 4 rise");

	a_word_kept: assert property (
		!ctrl_word_valid_in |=> $stable(ctrl_word_out)
	) else $error("control word copy changed without a host update");

	a_screen_relight: assert property (
		screen_switch_req_in && !scr_fall |=> backlight_on_out
	) else $error("screen switch did not relight backlight");

	a_idle_off: assert property (
		idle_expire && idle_off_enable_in && !activity && !screen_switch_req_in
			|=> !backlight_on_out
	) else $error("idle interval did not turn backlight off");

	a_startup_quiet: assert property (
		ctrl_word_valid_in && !st_r.seen |=> !hist_print_req_out
			&& !report_print_req_out
	) else $error("start-up word caused a print request");

	a_other_bits: assert property (
		upd && ((ctrl_word_in ^ st_r.word) & THC_ACTIVE_MASK) == '0
			&& !key_edge && !screen_switch_req_in && !idle_expire
			|=> $stable(backlight_on_out) && !hist_print_req_out
			&& !report_print_req_out
	) else $error("unused control word bit changed terminal state");

	a_blank_kept: assert property (
		attr_blank_in && !ctrl_word_valid_in && !key_edge
			&& !screen_switch_req_in && !idle_expire
			|=> $stable(ctrl_word_out) && $stable(backlight_on_out)
	) else $error("screen blanking altered word copy or backlight");

	a_hist_held: assert property (
		upd && st_r.word[THC_BIT_HIST] |=> !hist_print_req_out
	) else $error("history bit held high requested another print");

	a_report_held: assert property (
		upd && st_r.word[THC_BIT_REPORT] |=> !report_print_req_out
	) else $error("report bit held high requested another print");

	a_idle_disabled: assert property (
		!idle_off_enable_in && backlight_on_out && !scr_fall
			|=> backlight_on_out
	) else $error("backlight went off with idle option disabled");

	a_idle_single: assert property (
		idle_expire |=> !idle_expire
	) else $error("idle expiry was not a single pulse");

	a_startup_light: assert property (
		ctrl_word_valid_in && !st_r.seen && !key_edge
			&& !screen_switch_req_in && !idle_expire |=> $stable(backlight_on_out)
	) else $error("start-up word changed the backlight");

	a_word_load: assert property (
		ctrl_word_valid_in |=> ctrl_word_out == $past(ctrl_word_in)
	) else $error("word copy does not hold the fetched word");

	a_hist_word: assert property (
		hist_print_req_out |-> ctrl_word_out[THC_BIT_HIST]
	) else $error("history print requested while bit 5 reads 0");
endmodule

// *** core/thc_idle_timer.sv ***
`timescale 1ns/10ps
module thc_idle_timer
	import thc_pkg::*;
#(
	parameter int TICK_CYCLES = THC_TICK_CYC,
	parameter int IDLE_TICKS = THC_IDLE_MS
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// control
	input wire logic enable_in,
	input wire logic restart_in,
	// event
	output logic expire_out
);
	localparam int PW = $clog2(TICK_CYCLES + 1);
	localparam int TW = $clog2(IDLE_TICKS + 1);

	typedef struct packed {
		logic [PW-1:0] presc;
		logic [TW-1:0] ticks;
		logic fired;
		logic expire;
	} thc_tmr_s;

	thc_tmr_s st_r;
	thc_tmr_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.expire = 1'b0;
		if (restart_in || !enable_in) begin
			st_nxt.presc = '0;
			st_nxt.ticks = '0;
			st_nxt.fired = 1'b0;
		end else if (!st_r.fired) begin
			// one-shot: after firing, wait for the next restart
			if (st_r.presc == PW'(TICK_CYCLES - 1)) begin
				st_nxt.presc = '0;
				if (st_r.ticks == TW'(IDLE_TICKS - 1)) begin
					st_nxt.ticks = '0;
					st_nxt.fired = 1'b1;
					st_nxt.expire = 1'b1;
				end else begin
					st_nxt.ticks = st_r.ticks + TW'(1);
				end
			end else begin
				st_nxt.presc = st_r.presc + PW'(1);
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expire_out = st_r.expire;
endmodule

// *** core/thc_pkg.sv ***
package thc_pkg;
	// control word layout
	localparam int THC_WORD_W = 16;
	localparam int THC_BIT_SCREEN = 15;
	localparam int THC_BIT_HIST = 5;
	localparam int THC_BIT_REPORT = 4;
	localparam logic [15:0] THC_ACTIVE_MASK = 16'h8030;
	localparam logic [15:0] THC_WORD_RST = 16'h0000;
	localparam logic THC_LIGHT_RST = 1'b1;

	// timing: clock rate and the idle timer tick, in their own units
	localparam int THC_CLK_KHZ = 20000;
	localparam int THC_TICK_US = 1000;
	localparam int THC_TICK_CYC = THC_TICK_US * THC_CLK_KHZ / 1000;
	// idle interval before automatic backlight off, in ticks (ms)
	localparam int THC_IDLE_MS = 60000;
endpackage

// *** testbench/test_terminal_host_control_word.sv ***
`timescale 1ns/10ps
module test_terminal_host_control_word;
	import thc_pkg::*;
	logic ref_clk_in, reset_in, key, scr, blank, idle_en, valid;
	logic light, hist, rep;
	logic [15:0] word, wout;
	int n_mismatch, checked, n_hist, n_rep;
	thc_control_word #(.TICK_CYCLES(4), .IDLE_TICKS(5)) u_thc_control_word (
		.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.ctrl_word_in(word), .ctrl_word_valid_in(valid),
		.key_press_in(key), .screen_switch_req_in(scr),
		.attr_blank_in(blank), .idle_off_enable_in(idle_en),
		.backlight_on_out(light), .hist_print_req_out(hist),
		.report_print_req_out(rep), .ctrl_word_out(wout));
	thc_host_model u_thc_host_model (.ref_clk_in(ref_clk_in),
		.ctrl_word_out(word), .ctrl_word_valid_out(valid));
	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		if (hist === 1'b1) n_hist++;
		if (rep === 1'b1) n_rep++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	// write a word, count print pulses, check backlight
	task automatic wr(input logic [15:0] w, input int h, input int r,
			input logic l);
		n_hist = 0;
		n_rep = 0;
		u_thc_host_model.put(w);
		cyc(4);
		chk(16'(n_hist), 16'(h));
		chk(16'(n_rep), 16'(r));
		chk({15'h0, light}, {15'h0, l});
	endtask
	task automatic t_start;
		chk({15'h0, light}, 16'h0001);
		chk(wout, 16'h0000);
		wr(16'h8030, 0, 0, 1'b1);
	endtask
	task automatic t_print;
		wr(16'h8020, 0, 0, 1'b1);
		wr(16'h8030, 0, 1, 1'b1);
		wr(16'h8030, 0, 0, 1'b1);
		wr(16'h8010, 0, 0, 1'b1);
		wr(16'h8030, 1, 0, 1'b1);
		wr(16'hFFFF, 0, 0, 1'b1);
		wr(16'h8030, 0, 0, 1'b1);
	endtask
	task automatic t_light;
		blank = 1'b1;
		wr(16'h0030, 0, 0, 1'b0);
		chk(wout, 16'h0030);
		key = 1'b1;
		cyc(6);
		key = 1'b0;
		chk({15'h0, light}, 16'h0001);
		chk(wout, 16'h0030);
		wr(16'h8030, 0, 0, 1'b1);
		wr(16'h0030, 0, 0, 1'b0);
		wr(16'h8030, 0, 0, 1'b1);
		wr(16'h0030, 0, 0, 1'b0);
		scr = 1'b1;
		cyc(1);
		scr = 1'b0;
		cyc(2);
		chk({15'h0, light}, 16'h0001);
		blank = 1'b0;
	endtask
	// idle interval of the bench build: 4 cycles a tick, 5 ticks
	task automatic t_idle;
		idle_en = 1'b1;
		cyc(20);
		chk({15'h0, light}, 16'h0001);
		cyc(2);
		chk({15'h0, light}, 16'h0000);
		idle_en = 1'b0;
		scr = 1'b1;
		cyc(1);
		scr = 1'b0;
		cyc(2);
		chk({15'h0, light}, 16'h0001);
		cyc(30);
		chk({15'h0, light}, 16'h0001);
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		n_mismatch = 0;
		checked = 0;
		reset_in = 1'b1;
		{key, scr, blank, idle_en} = 4'h0;
		cyc(16);
		reset_in = 1'b0;
		t_start;
		t_print;
		t_light;
		t_idle;
		print_verdict;
	end
endmodule

// *** testbench/thc_host_model.sv ***
`timescale 1ns/10ps
module thc_host_model
	import thc_pkg::*;
(
	// clock
	input wire logic ref_clk_in,
	// control word fetched from host memory
	output logic [THC_WORD_W-1:0] ctrl_word_out,
	output logic ctrl_word_valid_out
);
	initial begin
		ctrl_word_out = THC_WORD_RST;
		ctrl_word_valid_out = 1'b0;
	end
	// one fetch per write; stale word shown inverted after the fetch
	task automatic put(input logic [THC_WORD_W-1:0] w);
		@(posedge ref_clk_in);
		#1;
		ctrl_word_out = w;
		ctrl_word_valid_out = 1'b1;
		@(posedge ref_clk_in);
		#1;
		ctrl_word_valid_out = 1'b0;
		ctrl_word_out = ~w;
	endtask
endmodule
